/* hdl/lcd_pkg.sv */
// Constants shared by the LCD command decoder
package lcd_pkg;
	localparam logic [3:0] OP_HOME = 4'h1;
	localparam logic [3:0] OP_DISP = 4'h3;
	localparam logic [3:0] OP_PWR_SAVE = 4'h4;
	localparam logic [3:0] OP_PWR_CTRL = 4'h5;
	localparam logic [3:0] OP_SYS_SET = 4'h6;
	localparam logic [3:0] OP_VOLUME = 4'h7;
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_TEST = 8'h0A;
	localparam logic [6:0] ADDR_HOME = 7'h30;
	localparam logic [6:0] ADDR_RST = 7'h00;
	localparam logic [6:0] GLYPH_LAST = 7'h1F;
	localparam logic [6:0] TEXT_FIRST = 7'h30;
	localparam logic [6:0] SYM_FIRST = 7'h70;
	localparam logic [6:0] SYM_LAST = 7'h75;
	localparam int GLYPH_CODES = 4;
	localparam int GLYPH_ROWS = 7;
	localparam int GLYPH_COLS = 5;
	localparam int TEXT_WORDS = 64;
	localparam int SYM_BYTES = 6;
	localparam logic [1:0] LINES_RST = 2'h0;
	localparam logic [3:0] VOLUME_RST = 4'h0;
endpackage : lcd_pkg

/* hdl/lcd_sync2.sv */
// Two-flop synchroniser for one pin
`timescale 1ns/1ns
module lcd_sync2 (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic d_i,
	output logic q_o
);
	logic s1_q;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_q <= 1'b0;
			q_o <= 1'b0;
		end else begin
			s1_q <= d_i;
			q_o <= s1_q;
		end
	end
endmodule : lcd_sync2

/* hdl/lcd_decoder.sv */
// Command and data write decoder of the character LCD controller
// How it works
// - Data write stores the byte at the address counter location.
// - Each stored data byte increments the address counter by one.
// - Upper nibble 0001 presets the address counter to cursor home.
// - Nibble 0011 loads marker shown, flash, twin and picture on.
// - Nibble 0100 loads oscillator enable from D1, power save from D0.
// - Nibble 0101 with D3 zero loads regulator, follower and boost.
// - Nibble 0110 with D3:D2 not both one loads line count from D3:D2 and glyph RAM use from D0.
// - Nibble 0111 loads the four-bit contrast volume.
// - D7 set loads the low seven bits into the address counter.
// - Addresses 00H-7FH: glyph 00-1F, text 30-6F, symbols from 70H.
// - Codes 00H-03H read glyph RAM when enabled, else glyph ROM.
// - Glyph ROM gives 5x7 patterns for 256 codes.
// - Glyph RAM holds four 5x7 user patterns.
// - Glyph RAM rows sit at consecutive bytes; low five bits kept.
// - A one in a pattern bit lights the dot.
// - Symbol register holds 48 display bits.
`timescale 1ns/1ns
module lcd_decoder (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic store_pulse_i,
	input wire logic register_select_i,
	input wire logic [7:0] data_i,
	input wire logic [6:0] text_raddr_i,
	input wire logic [1:0] glyph_row_code_i,
	input wire logic [2:0] glyph_row_i,
	input wire logic [4:0] rom_row_i,
	output logic [7:0] text_rdata_o,
	output logic [4:0] glyph_row_o,
	output logic glyph_from_ram_o,
	output logic [47:0] symbols_o,
	output logic [6:0] addr_counter_o,
	output logic marker_shown_o,
	output logic marker_flash_o,
	output logic twin_marker_o,
	output logic picture_on_o,
	output logic osc_on_o,
	output logic low_energy_on_o,
	output logic regulator_on_o,
	output logic unity_gain_on_o,
	output logic boost_on_o,
	output logic [1:0] line_count_o,
	output logic glyph_ram_use_o,
	output logic [3:0] volume_o
);
	logic strobe_s;
	logic strobe_d1_q;
	logic [7:0] text_mem [0:lcd_pkg::TEXT_WORDS-1];
	logic [4:0] glyph_mem [0:lcd_pkg::GLYPH_CODES*8-1];
	logic [7:0] sym_mem [0:lcd_pkg::SYM_BYTES-1];
	logic [6:0] ac_q;

	lcd_sync2 u_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.d_i(store_pulse_i),
		.q_o(strobe_s)
	);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strobe_d1_q <= 1'b0;
		end else begin
			strobe_d1_q <= strobe_s;
		end
	end

	// Byte and select pass the same two flops as the strobe
	wire [8:0] pin_raw = {register_select_i, data_i};
	logic [8:0] pin_s;
	genvar k;
	for (k = 0; k < 9; k = k + 1) begin : g_pin_sync
		lcd_sync2 u_pin (
			.clk_i(clk_i),
			.rstn_i(rstn_i),
			.d_i(pin_raw[k]),
			.q_o(pin_s[k])
		);
	end
	wire [7:0] byte_s = pin_s[7:0];
	wire rs_s = pin_s[8];
	wire wr_go = strobe_s & ~strobe_d1_q;
	wire data_wr = wr_go & rs_s;
	wire cmd_wr = wr_go & ~rs_s;
	wire [3:0] hi = byte_s[7:4];
	wire is_nop = cmd_wr & (byte_s == lcd_pkg::OP_NOP);
	wire is_test = cmd_wr & (byte_s == lcd_pkg::OP_TEST);
	wire is_addr = cmd_wr & byte_s[7];
	wire is_home = cmd_wr & (hi == lcd_pkg::OP_HOME);
	wire is_disp = cmd_wr & (hi == lcd_pkg::OP_DISP);
	wire is_psave = cmd_wr & (hi == lcd_pkg::OP_PWR_SAVE);
	wire is_pctl = cmd_wr & (hi == lcd_pkg::OP_PWR_CTRL) & ~byte_s[3];
	wire is_sys = cmd_wr & (hi == lcd_pkg::OP_SYS_SET) & ~(&byte_s[3:2]);
	wire is_vol = cmd_wr & (hi == lcd_pkg::OP_VOLUME);
	// Map areas
	wire in_glyph = (ac_q <= lcd_pkg::GLYPH_LAST);
	wire in_text = (ac_q >= lcd_pkg::TEXT_FIRST) & (ac_q < lcd_pkg::SYM_FIRST);
	wire in_sym = (ac_q >= lcd_pkg::SYM_FIRST) & (ac_q <= lcd_pkg::SYM_LAST);
	wire [6:0] text_idx = ac_q - lcd_pkg::TEXT_FIRST;
	wire [6:0] sym_idx = ac_q - lcd_pkg::SYM_FIRST;
	wire [6:0] text_ridx = text_raddr_i - lcd_pkg::TEXT_FIRST;

	// Address counter; NOP and test code fall through unchanged
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ac_q <= lcd_pkg::ADDR_RST;
		end else if (is_addr) begin
			ac_q <= byte_s[6:0];
		end else if (is_home) begin
			ac_q <= lcd_pkg::ADDR_HOME;
		end else if (data_wr) begin
			ac_q <= ac_q + 7'h01;
		end
	end

	// Memory stores, no reset needed
	always_ff @(posedge clk_i) begin
		if (data_wr & in_text) begin
			text_mem[text_idx[5:0]] <= byte_s;
		end
		if (data_wr & in_glyph) begin
			glyph_mem[ac_q[4:0]] <= byte_s[4:0];
		end
		if (data_wr & in_sym) begin
			sym_mem[sym_idx[2:0]] <= byte_s;
		end
	end

	// Control flags
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			marker_shown_o <= 1'b0;
			marker_flash_o <= 1'b0;
			twin_marker_o <= 1'b0;
			picture_on_o <= 1'b0;
			osc_on_o <= 1'b0;
			low_energy_on_o <= 1'b0;
			regulator_on_o <= 1'b0;
			unity_gain_on_o <= 1'b0;
			boost_on_o <= 1'b0;
			line_count_o <= lcd_pkg::LINES_RST;
			glyph_ram_use_o <= 1'b0;
			volume_o <= lcd_pkg::VOLUME_RST;
		end else begin
			if (is_disp) begin
				{marker_shown_o, marker_flash_o} <= byte_s[3:2];
				{twin_marker_o, picture_on_o} <= byte_s[1:0];
			end
			if (is_psave) begin
				osc_on_o <= byte_s[1];
				low_energy_on_o <= byte_s[0];
			end
			if (is_pctl) begin
				regulator_on_o <= byte_s[2];
				unity_gain_on_o <= byte_s[1];
				boost_on_o <= byte_s[0];
			end
			if (is_sys) begin
				line_count_o <= byte_s[3:2];
				glyph_ram_use_o <= byte_s[0];
			end
			if (is_vol) begin
				volume_o <= byte_s[3:0];
			end
		end
	end

	// Readout for the display side
	wire use_ram = glyph_ram_use_o & (text_rdata_o[7:2] == 6'h00);
	wire [4:0] ram_row = glyph_mem[{glyph_row_code_i, glyph_row_i}];
	wire txt_ok = text_ridx < 7'(lcd_pkg::TEXT_WORDS);
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			text_rdata_o <= 8'h00;
			glyph_row_o <= 5'h00;
			glyph_from_ram_o <= 1'b0;
			symbols_o <= 48'h0;
			addr_counter_o <= 7'h00;
		end else begin
			text_rdata_o <= txt_ok ? text_mem[text_ridx[5:0]] : 8'h00;
			glyph_from_ram_o <= use_ram;
			glyph_row_o <= use_ram ? ram_row : rom_row_i;
			symbols_o <= {sym_mem[5], sym_mem[4], sym_mem[3],
				sym_mem[2], sym_mem[1], sym_mem[0]};
			addr_counter_o <= ac_q;
		end
	end

	a_data_incr: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		data_wr |=> ac_q == $past(ac_q) + 7'h01)
		else $error("address counter did not step after data");
	a_ac_hold: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		!(data_wr || is_addr || is_home) |=> $stable(ac_q))
		else $error("address counter moved without cause");
	a_addr_load: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		is_addr |=> ac_q == $past(byte_s[6:0]))
		else $error("address load wrong");
	a_home_load: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		is_home |=> ac_q == lcd_pkg::ADDR_HOME)
		else $error("cursor home wrong");
	a_nop_still: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		is_nop |=> $stable(ac_q) && $stable(volume_o)
		&& $stable(line_count_o) && $stable(glyph_ram_use_o))
		else $error("nop changed state");
	a_test_still: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		is_test |=> $stable(ac_q) && $stable(volume_o)
		&& $stable(line_count_o) && $stable(glyph_ram_use_o))
		else $error("test code changed state");
	a_data_quiet: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		data_wr |=> $stable(volume_o) && $stable(line_count_o)
		&& $stable(osc_on_o) && $stable(marker_shown_o))
		else $error("data write changed a control");
	a_vol_load: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		is_vol |=> volume_o == $past(byte_s[3:0]))
		else $error("volume not loaded");
	a_disp_load: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		is_disp |=> {marker_shown_o, marker_flash_o, twin_marker_o,
		picture_on_o} == $past(byte_s[3:0]))
		else $error("display bits wrong");
	a_psave_load: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		is_psave |=> osc_on_o == $past(byte_s[1])
		&& low_energy_on_o == $past(byte_s[0]))
		else $error("power save wrong");
	a_pctl_load: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		is_pctl |=> {regulator_on_o, unity_gain_on_o, boost_on_o}
		== $past(byte_s[2:0]))
		else $error("power control wrong");
	a_pctl_skip: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		cmd_wr && hi == lcd_pkg::OP_PWR_CTRL && byte_s[3]
		|=> $stable(regulator_on_o) && $stable(unity_gain_on_o)
		&& $stable(boost_on_o))
		else $error("power control taken with D3 set");
	a_sys_load: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		is_sys |=> line_count_o == $past(byte_s[3:2])
		&& glyph_ram_use_o == $past(byte_s[0]))
		else $error("system set wrong");
	a_glyph_src: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		!glyph_ram_use_o |=> !glyph_from_ram_o)
		else $error("glyph RAM used while disabled");
endmodule : lcd_decoder

/* sim/lcd_host_model.sv */
// Host processor model writing command and data bytes
`timescale 1ns/1ns
module lcd_host_model (
	input wire logic clk_i,
	output logic store_pulse_o,
	output logic register_select_o,
	output logic [7:0] data_o
);
	initial begin
		store_pulse_o = 1'b0;
		register_select_o = 1'b0;
		data_o = 8'h00;
	end
	// One byte, command 0AH skipped: strobe high 4 clk, then low 3 clk
	task automatic write(input logic rs, input logic [7:0] b);
		if (!rs && b == 8'h0A) return;
		@(posedge clk_i);
		register_select_o <= rs;
		data_o <= b;
		store_pulse_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		store_pulse_o <= 1'b0;
		@(posedge clk_i);
		data_o <= ~b;
		register_select_o <= ~rs;
		repeat (2) @(posedge clk_i);
	endtask : write
endmodule : lcd_host_model

/* sim/lcd_decoder_bench.sv */
// Self-checking bench of the LCD command decoder
`timescale 1ns/1ns
module lcd_command_decoder_bench;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic store_pulse_i, register_select_i;
	logic [7:0] data_i, text_rdata_o;
	logic [6:0] text_raddr_i = 7'h30;
	logic [6:0] addr_counter_o;
	logic [1:0] glyph_row_code_i = 2'h0;
	logic [2:0] glyph_row_i = 3'h0;
	logic [4:0] rom_row_i = 5'h15;
	logic [4:0] glyph_row_o;
	logic [47:0] symbols_o;
	logic [1:0] line_count_o;
	logic [3:0] volume_o;
	logic glyph_from_ram_o, marker_shown_o, marker_flash_o, twin_marker_o;
	logic picture_on_o, osc_on_o, low_energy_on_o, regulator_on_o;
	logic unity_gain_on_o, boost_on_o, glyph_ram_use_o;
	logic [39:0] tbl [18];
	int fail_count = 0;
	int total_checks = 0;
	logic [15:0] exp_ctl;
	wire [15:0] ctl = {marker_shown_o, marker_flash_o, twin_marker_o,
		picture_on_o, osc_on_o, low_energy_on_o, regulator_on_o,
		unity_gain_on_o, boost_on_o, line_count_o, glyph_ram_use_o, volume_o};

	always #20 clk_i = ~clk_i;

	lcd_decoder uut (.clk_i, .rstn_i, .store_pulse_i, .register_select_i,
		.data_i, .text_raddr_i, .glyph_row_code_i, .glyph_row_i, .rom_row_i,
		.text_rdata_o, .glyph_row_o, .glyph_from_ram_o, .symbols_o,
		.addr_counter_o, .marker_shown_o, .marker_flash_o, .twin_marker_o,
		.picture_on_o, .osc_on_o, .low_energy_on_o, .regulator_on_o,
		.unity_gain_on_o, .boost_on_o, .line_count_o, .glyph_ram_use_o,
		.volume_o);
	lcd_host_model host (.clk_i, .store_pulse_o(store_pulse_i),
		.register_select_o(register_select_i), .data_o(data_i));

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic final_report;
		$display("checks=%0d fails=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	initial begin
		#100000;
		fail_count++;
		final_report();
	end

	initial begin
		// Rows: select, byte, display, power, system, volume, counter
		tbl = '{40'h0_3F_F_00_0_0_00, 40'h0_36_6_00_0_0_00,
			40'h0_4E_6_10_0_0_00, 40'h0_43_6_18_0_0_00, 40'h0_57_6_1F_0_0_00,
			40'h0_5D_6_1F_0_0_00, 40'h0_52_6_1A_0_0_00, 40'h0_69_6_1A_5_0_00,
			40'h0_6C_6_1A_5_0_00, 40'h0_75_6_1A_5_5_00, 40'h0_00_6_1A_5_5_00,
			40'h0_0A_6_1A_5_5_00, 40'h0_9F_6_1A_5_5_1F, 40'h1_AB_6_1A_5_5_20,
			40'h0_1F_6_1A_5_5_30, 40'h1_41_6_1A_5_5_31, 40'h0_FF_6_1A_5_5_7F,
			40'h1_55_6_1A_5_5_00};
		repeat (5) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		chk(ctl, 16'h0000);
		chk(addr_counter_o, 7'h00);
		$display("test reset done");
		foreach (tbl[i]) begin
			host.write(tbl[i][36], tbl[i][35:28]);
			exp_ctl = {tbl[i][27:24], tbl[i][20:16], tbl[i][14:12],
				tbl[i][11:8]};
			chk(ctl, exp_ctl);
			chk(addr_counter_o, tbl[i][6:0]);
		end
		$display("test table done");
		// User pattern row 0 and code 00H at 32H, glyph RAM in use
		host.write(1'b0, 8'h80);
		host.write(1'b1, 8'hEF);
		host.write(1'b0, 8'hB2);
		host.write(1'b1, 8'h00);
		chk(text_rdata_o, 8'h41);
		text_raddr_i <= 7'h32;
		repeat (3) @(posedge clk_i);
		chk({glyph_from_ram_o, glyph_row_o}, 6'h2F);
		host.write(1'b0, 8'h68);
		repeat (2) @(posedge clk_i);
		chk({glyph_from_ram_o, glyph_row_o}, 6'h15);
		text_raddr_i <= 7'h20;
		repeat (2) @(posedge clk_i);
		chk(text_rdata_o, 8'h00);
		$display("test glyph done");
		host.write(1'b0, 8'hF5);
		host.write(1'b1, 8'hC3);
		chk(symbols_o[47:40], 8'hC3);
		// Zero the first symbol byte, as for the third common
		host.write(1'b0, 8'hF0);
		host.write(1'b1, 8'h00);
		chk(symbols_o[7:0], 8'h00);
		$display("test symbol done");
		rstn_i <= 1'b0;
		@(posedge clk_i);
		chk(ctl, 16'h0000);
		chk(addr_counter_o, 7'h00);
		rstn_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(symbols_o[47:40], 8'hC3);
		// Code 01H row 0 at 08H, read back after reset
		host.write(1'b0, 8'h88);
		host.write(1'b1, 8'hF1);
		chk(addr_counter_o, 7'h09);
		host.write(1'b0, 8'h61);
		chk(ctl, 16'h0010);
		text_raddr_i <= 7'h32;
		glyph_row_code_i <= 2'h1;
		repeat (3) @(posedge clk_i);
		chk({glyph_from_ram_o, glyph_row_o}, 6'h31);
		$display("test second reset done");
		final_report();
	end
endmodule : lcd_command_decoder_bench
